//--- design/apcsr_fifo.sv
// Result word FIFO with valid and ready on both sides
`timescale 1ns/10ps
module apcsr_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PTR_W = $clog2(DEPTH);            // Pointer width

	////////////////////////////////////////////////////////////////////////////////
	// Storage and pointers
	logic [WIDTH-1:0] mem_reg [DEPTH];               // Word storage
	logic [PTR_W-1:0] wrPtr_reg;                     // Next slot to write
	logic [PTR_W-1:0] rdPtr_reg;                     // Next slot to read
	logic [PTR_W:0]   count_reg;                     // Words held
	logic             doPush;                        // Write this cycle
	logic             doPop;                         // Read this cycle
	logic [PTR_W-1:0] wrPtrInc;                      // Wrapped write pointer
	logic [PTR_W-1:0] rdPtrInc;                      // Wrapped read pointer

	// Honest full and empty
	assign inReady  = (count_reg != (PTR_W+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem_reg[rdPtr_reg];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;
	assign wrPtrInc = (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
	assign rdPtrInc = (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;

	// Write into the slot under the write pointer
	always_ff @(posedge clk)
	begin
		if (doPush)
			mem_reg[wrPtr_reg] <= inData;
	end

	// Pointer and occupancy upkeep; flush empties
	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_reg <= wrPtrInc;
			if (doPop)
				rdPtr_reg <= rdPtrInc;
			count_reg <= count_reg + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
		end
	end

endmodule

//--- design/apcsr_pkg.sv
// Shared constants, types and lookups of the converter pin control and readout block
package apcsr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Word layout
	localparam int DATA_W     = 24;                  // Result bits per word
	localparam int WORD_W     = DATA_W + 1;          // Result plus out-of-range bit
	localparam int FIFO_DEPTH = 8;                   // Result words buffered
	localparam int BIT_IDX_W  = 5;                   // Bit index width
	localparam logic [BIT_IDX_W-1:0] LAST_BIT_IDX = 5'h17; // Index of the result MSB

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_PERIOD_NS     = 20;           // Master clock period
	localparam int EXT_SCLK_MIN_NS   = 25;           // Shortest host shift clock period
	localparam int EXT_GAP_CYC       = 3;            // Host last fall to next ready rise
	// Cycles a word is held for the host before the next ready pulse
	localparam int EXT_HOLD_CYC      = (DATA_W * EXT_SCLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
		+ EXT_GAP_CYC;
	localparam int HOLD_W            = 8;            // Hold counter width
	localparam logic [HOLD_W-1:0] EXT_HOLD_LOAD = HOLD_W'(EXT_HOLD_CYC - 1); // Hold count preset
	localparam int CONV_W            = 10;           // Conversion counter width

	////////////////////////////////////////////////////////////////////////////////
	// Conversion periods in master clock cycles per rate code
	localparam logic [CONV_W-1:0] WB_PERIOD_0 = 10'h100; // Lowest wide-bandwidth rate
	localparam logic [CONV_W-1:0] WB_PERIOD_1 = 10'h080;
	localparam logic [CONV_W-1:0] WB_PERIOD_2 = 10'h040;
	localparam logic [CONV_W-1:0] WB_PERIOD_3 = 10'h020; // Highest wide-bandwidth rate
	localparam logic [CONV_W-1:0] LL_PERIOD_0 = 10'h22C; // Lowest low-latency rate
	localparam logic [CONV_W-1:0] LL_PERIOD_1 = 10'h126;
	localparam logic [CONV_W-1:0] LL_PERIOD_2 = 10'h0A7;
	localparam logic [CONV_W-1:0] LL_PERIOD_3 = 10'h06F; // Highest low-latency rate

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [1:0] SYNC_RST = 2'h0;          // Synchroniser stage reset

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed
	{
		logic       lowLatency;                      // Low-latency filter path
		logic       fastResponse;                    // Fast-response low-latency behaviour
		logic [1:0] rate;                            // Data rate code
	} apcsr_cfg_t;

	typedef struct packed
	{
		logic              overrange;                // Filter out of range
		logic [DATA_W-1:0] data;                     // Conversion result
	} apcsr_word_t;

	typedef enum {RD_IDLE, RD_RISE, RD_FALL, RD_HOLD} apcsr_rd_t;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion period for a filter setting
	function automatic logic [CONV_W-1:0] apcsr_period(input apcsr_cfg_t cfg);
		logic [CONV_W-1:0] p;
		p = WB_PERIOD_0;
		case ({cfg.lowLatency, cfg.rate})
			3'h0:    p = WB_PERIOD_0;
			3'h1:    p = WB_PERIOD_1;
			3'h2:    p = WB_PERIOD_2;
			3'h3:    p = WB_PERIOD_3;
			3'h4:    p = LL_PERIOD_0;
			3'h5:    p = LL_PERIOD_1;
			3'h6:    p = LL_PERIOD_2;
			default: p = LL_PERIOD_3;
		endcase
		return p;
	endfunction

endpackage

//--- design/apcsr_top.sv
// Pin-configured conversion control and serial result readout of a delta-sigma converter
//
// What this block does
// R1: Latency config low single-cycle, high fast-response
// R2: Path select low wide-bandwidth, high low-latency
// R3: Negative shift clock complement internally, else off
// R4: Shift clock output when select low, input high
// R5: Chip select high tri-states serial data output
// R6: Host ends shifting three clocks before ready
// R7: Start begins conversions and restarts the filter
// R8: Dedicated flag shows filter result out of range
// R9: Serial data on complementary positive/negative outputs
// R10: Ready indication on complementary output pair
// R11: Ready rises after final internal shift clock rise
// R12: Ready pulse lasts one master clock per result
// R13: Internal shift clock period at least one clock
// R14: Clock select low internal, high external shift clock
// R15: Interface select low differential, high single-ended
// R16: Start sampled on master clock rising edge
// R17: Power-down low shuts the block down
`timescale 1ns/10ps
module apcsr_top (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 power_down_n,
	input  wire logic                 latency_filter_config,
	input  wire logic                 filter_path_select,
	input  wire logic [1:0]           rate_select,
	input  wire logic                 startPin,
	input  wire logic                 chipSelect_n,
	input  wire logic                 sclkSelect,
	input  wire logic                 ifaceSelect_n,
	input  wire logic                 shiftClk,
	input  wire apcsr_pkg::apcsr_word_t filterResult,
	output apcsr_pkg::apcsr_cfg_t     filterCfg,
	output logic                      filterRestart,
	output logic                      filter_overrange_flag,
	output logic                      sample_readyP,
	output logic                      sample_readyN,
	output logic                      sclkPOut,
	output logic                      sclkPOe,
	output logic                      sclkNOut,
	output logic                      sclkNOe,
	output logic                      doutPOut,
	output logic                      doutPOe,
	output logic                      doutNOut,
	output logic                      doutNOe
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	localparam int PIN_N = 9;                        // Pins crossing into the clock domain

	logic [PIN_N-1:0] pinRaw;                        // Pins as they arrive
	logic [PIN_N-1:0] syncA_reg;                     // First stage, read only by second
	logic [PIN_N-1:0] syncB_reg;                     // Second stage, safe to use
	logic             pwrOnS;                        // Powered up
	logic             latCfgS;                       // Latency config
	logic             pathS;                         // Filter path
	logic [1:0]       rateS;                         // Data rate code
	logic             startS;                        // Start level
	logic             extClkS;                       // Host supplies shift clock
	logic             diffS;                         // Differential signalling chosen
	logic             csActiveS;                     // Chip select asserted

	assign pinRaw = {power_down_n, latency_filter_config, filter_path_select, rate_select,
		startPin, sclkSelect, ifaceSelect_n, chipSelect_n};

	// Two flip-flops on every pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
					{syncB_reg[gi], syncA_reg[gi]} <= apcsr_pkg::SYNC_RST;
				else
					{syncB_reg[gi], syncA_reg[gi]} <= {syncA_reg[gi], pinRaw[gi]};
			end
		end
	endgenerate

	assign pwrOnS    = syncB_reg[8];                  // R17
	assign latCfgS   = syncB_reg[7];
	assign pathS     = syncB_reg[6];
	assign rateS     = syncB_reg[5:4];
	assign startS    = syncB_reg[3];                  // R16
	assign extClkS   = syncB_reg[2];                  // R14
	assign diffS     = !syncB_reg[1];                 // R15
	assign csActiveS = !syncB_reg[0];                 // R5

	////////////////////////////////////////////////////////////////////////////////
	// Filter configuration
	apcsr_pkg::apcsr_cfg_t cfgNext;                  // Configuration from pins

	assign cfgNext.lowLatency   = pathS;             // R2
	assign cfgNext.fastResponse = latCfgS;           // R1
	assign cfgNext.rate         = rateS;

	// Hand the settings to the filter
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			filterCfg <= '0;
		else
			filterCfg <= cfgNext;                     // R1 R2
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion control
	logic                             startPrev_reg; // Start one cycle ago
	logic                             convActive_reg; // Conversions running
	logic                             firstConv_reg; // First result after start
	logic [apcsr_pkg::CONV_W-1:0]     convCnt_reg;   // Cycles into conversion
	logic                             pendValid_reg; // Result awaiting the FIFO
	apcsr_pkg::apcsr_word_t           pendWord_reg;  // Captured result
	logic                             startRise;     // Start edge seen
	logic                             restart;       // Flush and restart
	logic                             stall;         // FIFO back-pressure
	logic [apcsr_pkg::CONV_W-1:0]     period;        // Full conversion period
	logic [apcsr_pkg::CONV_W-1:0]     target;        // Cycles for this result
	logic                             convDone;      // Result due this cycle
	logic                             fifoInReady;   // FIFO can take a word

	assign startRise = startS && !startPrev_reg;
	assign restart   = startRise || !pwrOnS;
	assign stall     = pendValid_reg && !fifoInReady;
	assign period    = apcsr_pkg::apcsr_period(cfgNext);
	// Fast response lets the first low-latency result out after half a period
	assign target    = (firstConv_reg && cfgNext.lowLatency && cfgNext.fastResponse)
		? {1'b0, period[apcsr_pkg::CONV_W-1:1]} : period; // R1
	assign convDone  = convActive_reg && !stall && (convCnt_reg == target - 1'b1);

	// Start edge detection and filter restart pulse
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			{startPrev_reg, filterRestart} <= 2'h0;
		else
			{startPrev_reg, filterRestart} <= {startS, startRise && pwrOnS}; // R7
	end

	// Conversion sequencing; start restarts any conversion in flight
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !pwrOnS)
		begin
			convActive_reg <= 1'b0;                   // R17
			firstConv_reg  <= 1'b0;
			convCnt_reg    <= '0;
		end
		else if (startRise)
		begin
			convActive_reg <= 1'b1;                   // R7
			firstConv_reg  <= 1'b1;
			convCnt_reg    <= '0;
		end
		else if (convDone)
		begin
			// Continue only while start stays high
			convActive_reg <= startS;
			firstConv_reg  <= 1'b0;
			convCnt_reg    <= '0;
		end
		else if (convActive_reg && !stall)
			convCnt_reg <= convCnt_reg + 1'b1;
	end

	// Result capture; a new capture wins over the push that empties it
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || restart)
			pendValid_reg <= 1'b0;
		else
			pendValid_reg <= convDone || (pendValid_reg && !fifoInReady);
		if (!rst_n)
			pendWord_reg <= '0;
		else if (convDone)
			pendWord_reg <= filterResult;             // R8
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result buffer
	logic                   fifoOutValid;            // Word waiting for readout
	logic                   fifoPop;                 // Readout takes a word
	apcsr_pkg::apcsr_word_t fifoOut;                 // Head word

	apcsr_fifo #(
		.WIDTH (apcsr_pkg::WORD_W),
		.DEPTH (apcsr_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (sys_clk),
		.rst_n    (rst_n),
		.flush    (restart),
		.inValid  (pendValid_reg),
		.inReady  (fifoInReady),
		.inData   (pendWord_reg),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOut)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Readout sequencer
	apcsr_pkg::apcsr_rd_t          rdState_reg;      // Readout state
	apcsr_pkg::apcsr_rd_t          rdState_next;     // Next readout state
	apcsr_pkg::apcsr_word_t        holdWord_reg;     // Word being read out
	logic [apcsr_pkg::BIT_IDX_W-1:0] bitIdx_reg;     // Bit on the wire
	logic [apcsr_pkg::HOLD_W-1:0]  holdCnt_reg;      // Host read window
	logic                          sclkInt_reg;      // Generated shift clock
	logic                          doutInt_reg;      // Internal-mode data bit
	logic                          readyPulse;       // Ready this cycle
	logic                          lastFall;         // Final generated fall
	logic                          lastFallDly_reg;  // Final fall, one clock later

	assign fifoPop  = (rdState_reg == apcsr_pkg::RD_IDLE) && fifoOutValid && pwrOnS;
	assign lastFall = (rdState_reg == apcsr_pkg::RD_FALL) && (bitIdx_reg == '0);
	// External mode marks a word on load; internal mode after the last rise
	assign readyPulse = (fifoPop && extClkS) || lastFallDly_reg; // R11 R12

	// Next state of the readout
	always_comb
	begin
		rdState_next = rdState_reg;
		case (rdState_reg)
			apcsr_pkg::RD_IDLE:
				// Host clocks the word in external mode
				if (fifoPop)
					rdState_next = extClkS ? apcsr_pkg::RD_HOLD : apcsr_pkg::RD_RISE; // R14
			apcsr_pkg::RD_RISE:
				rdState_next = apcsr_pkg::RD_FALL;       // R13
			apcsr_pkg::RD_FALL:
				rdState_next = (bitIdx_reg == '0) ? apcsr_pkg::RD_IDLE : apcsr_pkg::RD_RISE;
			apcsr_pkg::RD_HOLD:
				// Keep the word still while the host shifts it out
				if (holdCnt_reg == '0)
					rdState_next = apcsr_pkg::RD_IDLE;   // R6
			default:
				rdState_next = apcsr_pkg::RD_IDLE;
		endcase
	end

	// Word, bit index and window counter
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			holdWord_reg <= '0;
			bitIdx_reg   <= '0;
			holdCnt_reg  <= '0;
		end
		else if (fifoPop)
		begin
			holdWord_reg <= fifoOut;
			bitIdx_reg   <= apcsr_pkg::LAST_BIT_IDX;
			holdCnt_reg  <= apcsr_pkg::EXT_HOLD_LOAD;
		end
		else
		begin
			if (rdState_reg == apcsr_pkg::RD_FALL && bitIdx_reg != '0)
				bitIdx_reg <= bitIdx_reg - 1'b1;
			if (rdState_reg == apcsr_pkg::RD_HOLD && holdCnt_reg != '0)
				holdCnt_reg <= holdCnt_reg - 1'b1;
		end
	end

	// State, generated clock, delayed end mark; ready waits a clock to follow the last pin rise
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !pwrOnS)
		begin
			rdState_reg     <= apcsr_pkg::RD_IDLE;    // R17
			lastFallDly_reg <= 1'b0;
			sclkInt_reg     <= 1'b0;
			doutInt_reg     <= 1'b0;
		end
		else
		begin
			rdState_reg     <= rdState_next;
			lastFallDly_reg <= lastFall;              // R11
			sclkInt_reg     <= (rdState_reg == apcsr_pkg::RD_RISE); // R13
			if (rdState_reg == apcsr_pkg::RD_RISE)
				doutInt_reg <= holdWord_reg.data[bitIdx_reg];
		end
	end
	// Ready pair, out-of-range flag and pin drivers; all idle in power-down
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !pwrOnS)
		begin
			sample_readyP         <= 1'b0;
			sample_readyN         <= 1'b1;
			filter_overrange_flag <= 1'b0;
			{sclkPOut, sclkNOut}  <= 2'h1;
			{sclkPOe, sclkNOe}    <= 2'h0;
			{doutPOe, doutNOe}    <= 2'h0;
		end
		else
		begin
			sample_readyP <= readyPulse;               // R12
			sample_readyN <= !readyPulse;              // R10
			if (readyPulse)
				filter_overrange_flag <= extClkS ? fifoOut.overrange : holdWord_reg.overrange; // R8
			sclkPOut      <= sclkInt_reg;
			sclkNOut      <= !sclkInt_reg;             // R3
			sclkPOe       <= !extClkS;                 // R4
			sclkNOe       <= !extClkS;                 // R3
			doutPOe       <= csActiveS;                // R5
			doutNOe       <= csActiveS && diffS;       // R9 R15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host-clocked shifter; chip select high clears it and ends the frame
	logic [apcsr_pkg::BIT_IDX_W-1:0] linkIdx_reg;    // Next bit for the host
	logic                            linkDout_reg;   // External-mode data bit

	// Word is still for the whole read window, so it is read across directly
	always_ff @(posedge shiftClk or posedge chipSelect_n)
	begin
		if (chipSelect_n)
		begin
			linkIdx_reg  <= apcsr_pkg::LAST_BIT_IDX;
			linkDout_reg <= 1'b0;
		end
		else
		begin
			linkDout_reg <= holdWord_reg.data[linkIdx_reg]; // R4
			linkIdx_reg  <= (linkIdx_reg == '0) ? apcsr_pkg::LAST_BIT_IDX : linkIdx_reg - 1'b1;
		end
	end

	// Data pair follows the active shifter
	assign doutPOut = extClkS ? linkDout_reg : doutInt_reg;   // R9
	assign doutNOut = extClkS ? !linkDout_reg : !doutInt_reg; // R9

endmodule

//--- tb/apcsr_assertions.sv
// Concurrent checks on the pin control and readout ports
`timescale 1ns/10ps
module apcsr_assertions (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic power_down_n,
	input wire logic startPin,
	input wire logic chipSelect_n,
	input wire logic sclkSelect,
	input wire logic ifaceSelect_n,
	input wire logic filterRestart,
	input wire logic sample_readyP,
	input wire logic sample_readyN,
	input wire logic sclkPOut,
	input wire logic sclkPOe,
	input wire logic sclkNOut,
	input wire logic sclkNOe,
	input wire logic doutPOut,
	input wire logic doutPOe,
	input wire logic doutNOut,
	input wire logic doutNOe
);
	// One clock domain, synchronous reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Steps of a restart, then ready, shift clock, data pair and power-down checks
	sequence s_startEdge;
		power_down_n && $rose(startPin);
	endsequence
	sequence s_restartPulse;
		filterRestart ##1 !filterRestart;
	endsequence
	property p_restart; s_startEdge |-> ##[1:4] s_restartPulse; endproperty
	a_restart: assert property (p_restart) else $error("restart pulse missing");
	property p_readyPulse; sample_readyP |=> !sample_readyP; endproperty
	a_readyPulse: assert property (p_readyPulse) else $error("ready longer than one cycle");
	property p_readyPair; sample_readyN != sample_readyP; endproperty
	a_readyPair: assert property (p_readyPair) else $error("ready pair not complementary");
	property p_readyAfterRise; (sclkPOe && $rose(sample_readyP)) |-> $past(sclkPOut) && !sclkPOut; endproperty
	a_readyAfterRise: assert property (p_readyAfterRise) else $error("ready not after last rise");
	property p_sclkHigh; (sclkPOe && sclkPOut) |=> !sclkPOut; endproperty
	a_sclkHigh: assert property (p_sclkHigh) else $error("shift clock high too long");
	property p_negClk; sclkNOe == sclkPOe && sclkNOut != sclkPOut; endproperty
	a_negClk: assert property (p_negClk) else $error("negative shift clock wrong");
	property p_extClk; sclkSelect [*5] |-> !sclkPOe && !sclkNOe; endproperty
	a_extClk: assert property (p_extClk) else $error("shift clock driven in host mode");
	property p_intClk; (!sclkSelect && power_down_n) [*5] |-> sclkPOe; endproperty
	a_intClk: assert property (p_intClk) else $error("shift clock not driven");
	property p_csOff; chipSelect_n [*5] |-> !doutPOe; endproperty
	a_csOff: assert property (p_csOff) else $error("data driven while deselected");
	property p_doutPair; doutNOut != doutPOut && (!doutNOe || doutPOe); endproperty
	a_doutPair: assert property (p_doutPair) else $error("data pair not complementary");
	property p_ifaceSe; ifaceSelect_n [*5] |-> !doutNOe; endproperty
	a_ifaceSe: assert property (p_ifaceSe) else $error("negative data driven single-ended");
	property p_power_down_n; (!power_down_n) [*5] |-> !doutPOe && !sclkPOe && !sample_readyP; endproperty
	a_power_down_n: assert property (p_power_down_n) else $error("outputs active in power-down");
endmodule

bind apcsr_top apcsr_assertions apcsr_assertions_i (.*);

//--- tb/apcsr_host.sv
// Host model that reads result words over the shift interface
`timescale 1ns/10ps
module apcsr_host (
	input  wire logic        sys_clk,
	input  wire logic        extMode,
	input  wire logic        sample_readyP,
	input  wire logic        sclkPOut,
	input  wire logic        doutBit,
	output logic             hostClk,
	output logic             chipSelect_n,
	output logic [23:0]      rxWord,
	output logic [7:0]       rxCount
);
	logic [23:0] shiftReg;   // Bits gathered so far
	logic        frameCs_n;  // Select during host-clocked frames
	// Held selected while the device clocks
	assign chipSelect_n = extMode ? frameCs_n : 1'b0;
	initial
	begin
		hostClk = 1'b0;
		frameCs_n = 1'b1;
		rxWord = 24'h000000;
		rxCount = 8'h00;
		shiftReg = 24'h000000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Device clock: take the bit during the high cycle
	always @(posedge sys_clk)
	begin
		if (!extMode && sclkPOut)
			shiftReg <= {shiftReg[22:0], doutBit};
		if (!extMode && sample_readyP)
		begin
			rxWord <= shiftReg;
			rxCount <= rxCount + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Host clock: one 24-edge frame per ready pulse, clock still between frames
	initial
	begin
		forever
		begin
			@(posedge sys_clk iff (extMode && sample_readyP));
			#3;
			frameCs_n = 1'b0;
			repeat (4) @(posedge sys_clk);
			#5;
			repeat (24)
			begin
				hostClk = 1'b1;
				#6;
				shiftReg = {shiftReg[22:0], doutBit};
				hostClk = 1'b0;
				#6;
			end
			// Frame closes long before the next ready rise
			frameCs_n = 1'b1;
			rxWord = shiftReg;
			rxCount = rxCount + 8'h01;
		end
	end
endmodule

//--- tb/apcsr_top_tb.sv
// Self-checking bench of the pin control and readout block
`timescale 1ns/10ps
module apcsr_top_tb;
	logic sys_clk, rst_n, power_down_n, latency_filter_config, filter_path_select;  // Pins
	logic [1:0] rate_select;                                                        // Rate pins
	logic startPin, sclkSelect, ifaceSelect_n, chipSelect_n, shiftClk, hostClk;     // Control
	apcsr_pkg::apcsr_word_t filterResult;                                           // Filter word
	apcsr_pkg::apcsr_cfg_t  filterCfg;                                              // Filter setting
	logic filterRestart, filter_overrange_flag, sample_readyP, sample_readyN;       // Outputs
	logic sclkPOut, sclkPOe, sclkNOut, sclkNOe, doutPOut, doutPOe, doutNOut, doutNOe, doutWire;
	logic [23:0] rxWord;   // Word seen by host
	logic [7:0]  rxCount;  // Words seen by host
	int numErrors, checks; // Tallies
	////////////////////////////////////////////////////////////////////////////////
	// Pin levels: host clock when released, changing pattern on floating data
	assign shiftClk = sclkPOe ? sclkPOut : hostClk;
	assign doutWire = doutPOe ? doutPOut : ~sys_clk;
	apcsr_top apcsr_top_i (.*);
	apcsr_host apcsr_host_i (.sys_clk(sys_clk), .extMode(sclkSelect), .sample_readyP(sample_readyP),
		.sclkPOut(sclkPOut), .doutBit(doutWire), .hostClk(hostClk), .chipSelect_n(chipSelect_n),
		.rxWord(rxWord), .rxCount(rxCount));
	// Master clock
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	// Compare and tally
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			numErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Convert continuously and read one word in the chosen clock mode
	task automatic read_word(input logic ext, input logic iface, input logic [3:0] cfg, input logic [24:0] w);
		logic [7:0] n;
		n = rxCount;
		@(posedge sys_clk);
		{filter_path_select, latency_filter_config, rate_select} <= cfg;
		sclkSelect <= ext;
		ifaceSelect_n <= iface;
		filterResult <= w;
		startPin <= 1'b1;
		for (int k = 0; k < 3000 && rxCount == n; k++) @(negedge sys_clk);
		check(32'(rxWord), 32'(w[23:0]));
		repeat (3) @(negedge sys_clk);
		check(32'(filter_overrange_flag), 32'(w[24]));
		@(posedge sys_clk);
		startPin <= 1'b0;
		repeat (700) @(posedge sys_clk);
		$display("test readout mode %0d done", ext);
	endtask
	// Verdict, reached from the tests and the watchdog
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		power_down_n = 1'b1;
		{filter_path_select, latency_filter_config, rate_select} = 4'h0;
		startPin = 1'b0;
		sclkSelect = 1'b0;
		ifaceSelect_n = 1'b0;
		filterResult = 25'h0000000;
		repeat (8) @(negedge sys_clk);
		check(32'({sample_readyP, sample_readyN, sclkPOe, doutPOe, filterRestart}), 32'h08);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		$display("test reset done");
		// Every path, latency and rate setting
		for (int i = 0; i < 16; i++)
		begin
			@(posedge sys_clk);
			{filter_path_select, latency_filter_config, rate_select} <= 4'(i);
			repeat (5) @(negedge sys_clk);
			check(32'(filterCfg), 32'(i));
		end
		$display("test config done");
		read_word(1'b0, 1'b0, 4'h3, 25'h1A5C3E7);
		read_word(1'b1, 1'b1, 4'hF, 25'h03C5A96);
		// Power-down with conversions requested
		@(posedge sys_clk);
		sclkSelect <= 1'b0;
		startPin <= 1'b1;
		power_down_n <= 1'b0;
		repeat (6) @(negedge sys_clk);
		check(32'({sclkPOe, doutPOe, sample_readyP, sample_readyN}), 32'h1);
		@(posedge sys_clk);
		power_down_n <= 1'b1;
		startPin <= 1'b0;
		repeat (20) @(posedge sys_clk);
		$display("test power-down done");
		summarize();
	end
	// Watchdog
	initial
	begin
		repeat (10000) @(posedge sys_clk);
		numErrors++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		summarize();
	end
endmodule
